// ===== logic/apms_pkg.sv
// shared constants and types of the adc power-mode sequencer
package apms_pkg;
  // ==========================================================
  // timing
  // ==========================================================
  localparam int CLK_PERIOD_PS = 8000;  // system clock period
  localparam int PU_TIME_US    = 1;     // longest power-up time
  // longest time: rounded down to whole cycles
  localparam int PU_CYC_INT    = (PU_TIME_US * 1000000) / CLK_PERIOD_PS;
  localparam int PU_W          = 7;
  localparam logic [PU_W-1:0] PU_CYC = PU_W'(PU_CYC_INT);
  // timer start value: covers the select sync lag, so 1 us counts from the pin
  localparam logic [PU_W-1:0] PU_SYNC = 7'h03;

  // ==========================================================
  // serial frame
  // ==========================================================
  localparam int FRAME_LEN = 16;  // clocks per conversion
  localparam int RES_W     = 12;  // result width
  localparam int CNT_W     = 5;   // falling-edge counter width
  localparam logic [3:0]       LEAD_ZEROS = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ZERO   = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE    = 5'h01;
  localparam logic [CNT_W-1:0] EDGE_PD    = 5'h02;  // power-down window start
  localparam logic [CNT_W-1:0] EDGE_STAY  = 5'h0A;  // stay-powered edge
  localparam logic [CNT_W-1:0] EDGE_TRACK = 5'h0D;  // back to track
  localparam logic [CNT_W-1:0] EDGE_DONE  = 5'h10;  // frame complete
  localparam logic [CNT_W-1:0] EDGE_LAST  = 5'h0F;  // last bit shifted
  localparam logic [3:0]       BIT_TOP    = 4'hE;   // bit sent on first fall

  // ==========================================================
  // link flags (link to core) and sync vector layout
  // ==========================================================
  localparam int FLG_W   = 5;
  localparam int FI_RISE = 4;  // an sclk rising edge seen in frame
  localparam int FI_GE2  = 3;
  localparam int FI_GE10 = 2;
  localparam int FI_GE13 = 1;
  localparam int FI_DONE = 0;
  localparam int SYN_W   = 6;
  localparam int SI_CS   = 5;  // frame select sits on top
  localparam logic [SYN_W-1:0] SYN_RST = 6'h20;  // select idles high

  // ==========================================================
  // operating modes
  // ==========================================================
  typedef enum logic [1:0] {
    ST_NORMAL = 2'b00,
    ST_PDOWN  = 2'b01,
    ST_WAKE   = 2'b10
  } apms_state_e;
endpackage

// ===== logic/apms_if.sv
// carrier between sequencer core and serial link logic
`timescale 1ns/1ps
`default_nettype none
interface apms_if;
  import apms_pkg::*;
  logic [FRAME_LEN-1:0] frame_word;  // word to shift, held stable in a frame
  logic [FLG_W-1:0]     flags;       // link levels, all from flops
  modport ctl (output frame_word, input flags);
  modport lnk (input frame_word, output flags);
endinterface
`default_nettype wire

// ===== logic/apms_link.sv
// serial-clock side: falling-edge counter, flags and result shifter
`timescale 1ns/1ps
`default_nettype none
module apms_link (
  // link clock and frame
  input  wire logic sclk,
  input  wire logic cs_n,
  // core side
  apms_if.lnk       bus,
  // serial result bit
  output var  logic dout
);
  import apms_pkg::*;

  // ==========================================================
  // state
  // ==========================================================
  logic [CNT_W-1:0] cnt_q, cnt_d;     // sclk falls since select fell
  logic [FLG_W-2:0] ge_q, ge_d;       // threshold flags, registered
  logic             dout_q, dout_d;   // shifted result bit
  logic             rise_q;           // any rising edge in frame
  logic [3:0]       bit_idx;          // word bit for this fall

  // ==========================================================
  // next values
  // ==========================================================
  // count falls per frame
  // select high holds everything cleared, so each frame starts from zero
  // without needing an edge on the stopped link clock
  always_comb begin
    cnt_d   = (cnt_q == EDGE_DONE) ? cnt_q : cnt_q + CNT_ONE;
    bit_idx = BIT_TOP - cnt_q[3:0];
    dout_d  = (cnt_q < EDGE_LAST) ? bus.frame_word[bit_idx] : 1'b0;
    // registered so the core never samples a comparator glitch
    ge_d[FI_GE2]  = (cnt_d >= EDGE_PD);
    ge_d[FI_GE10] = (cnt_d >= EDGE_STAY);
    ge_d[FI_GE13] = (cnt_d >= EDGE_TRACK);
    ge_d[FI_DONE] = (cnt_d >= EDGE_DONE);
  end

  // ==========================================================
  // falling- and rising-edge registers, cleared while select is high
  // ==========================================================
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      cnt_q  <= CNT_ZERO;
      ge_q   <= '0;
      dout_q <= 1'b0;  // first leading zero shows at select fall
    end else begin
      cnt_q  <= cnt_d;
      ge_q   <= ge_d;
      dout_q <= dout_d;
    end
  end

  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      rise_q <= 1'b0;
    end else begin
      rise_q <= 1'b1;
    end
  end

  assign bus.flags = {rise_q, ge_q};
  assign dout      = dout_q;
endmodule // apms_link
`default_nettype wire

// ===== logic/apms_top.sv
// power-mode sequencer of a serial sar adc, device side
// Operation
// - select up in edges 2..9: power down
// - power-down ends conversion, releases output
// - output released soon after select rises
// - select up before edge 2: stay normal
// - power-down: analog off, hold mode
// - dummy conversion powers up from select fall
// - ready within 1 us, dummy result invalid
// - wake aborted before edge 10: power down
// - wake: track on first sclk rise
// - initial power-up already in track
// - 16 clocks, release on 16th fall
// - four zeros then 12 bits, msb first
// - select low to edge 10 keeps power
`timescale 1ns/1ps
`default_nettype none
module apms_top (
  // system clock and reset
  input  wire logic                   CLK,
  input  wire logic                   RST_N,
  // serial link from host
  input  wire logic                   SCLK,
  input  wire logic                   CS_N,
  // result from the converter core
  input  wire logic [apms_pkg::RES_W-1:0] CONV_DATA,
  // serial result pin
  output var  logic                   CONV_RESULT_OUT,
  output var  logic                   CONV_RESULT_OUT_OE,
  // analog controls and status
  output var  logic                   ANALOG_ON,
  output var  logic                   TH_TRACK,
  output var  logic                   PWR_READY,
  output var  logic                   RESULT_VALID,
  output var  logic                   MODE_PDOWN
);
  import apms_pkg::*;

  // ==========================================================
  // declarations
  // ==========================================================
  apms_if link_bus ();                        // core to link carrier
  logic [SYN_W-1:0]   s1_q, s2_q;             // two-stage synchronisers
  logic               cs_prev_q;              // last synced select
  logic [FLG_W-1:0]   lat_q, lat_d;           // flags caught while low
  apms_state_e        state_q, state_d;       // operating mode
  logic [PU_W-1:0]    pu_q, pu_d;             // power-up timer
  logic [FRAME_LEN-1:0] word_q, word_d;       // result frame word
  logic               valid_q, valid_d;       // frame carries real data
  logic               rdy_q, rdy_d;           // fully powered, normal mode
  logic               pdn_q, pdn_d;           // power-down state
  logic [SYN_W-1:0]   syn_in;                 // levels into synchronisers
  logic               oe_q, oe_d;             // output drive enable
  logic               an_q, track_q, track_d; // analog power, t/h track
  logic               cs_s, cs_rise, cs_fall; // select, synced
  logic [FLG_W-1:0]   flg_s;                  // link flags, synced

  // ==========================================================
  // decoding shared by the normal and wake mode logic
  // ==========================================================
  // mode from sampled count
  function automatic apms_state_e mode_at_rise(input apms_state_e cur,
                                               input logic ge2, input logic ge10);
    if (ge10) begin
      mode_at_rise = ST_NORMAL;   // kept powered
    end else if (cur == ST_WAKE) begin
      mode_at_rise = ST_PDOWN;    // short wake falls back
    end else if (ge2) begin
      mode_at_rise = ST_PDOWN;    // power-down window
    end else begin
      mode_at_rise = ST_NORMAL;   // glitch ignored
    end
  endfunction

  // ==========================================================
  // link logic on its own clock
  // ==========================================================
  apms_link u_link (
    .sclk (SCLK),
    .cs_n (CS_N),
    .bus  (link_bus.lnk),
    .dout (CONV_RESULT_OUT)
  );

  // ==========================================================
  // crossings into the system clock
  // ==========================================================
  // first stage feeds only the second; select idles high
  // select sits on top of the flags, so no index runs past the flag vector
  assign syn_in = {CS_N, link_bus.flags};
  for (genvar i = 0; i < SYN_W; i++) begin : g_sync
    always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
        s1_q[i] <= SYN_RST[i];
        s2_q[i] <= SYN_RST[i];
      end else begin
        s1_q[i] <= syn_in[i];
        s2_q[i] <= s1_q[i];
      end
    end
  end

  assign cs_s    = s2_q[SI_CS];
  assign flg_s   = s2_q[FLG_W-1:0];
  assign cs_rise = cs_s & ~cs_prev_q;
  assign cs_fall = ~cs_s & cs_prev_q;

  // ==========================================================
  // next-state logic
  // ==========================================================
  always_comb begin
    // flags only grow within a frame, so they stay sticky from select fall;
    // a flag bit that clears a cycle before select resolves cannot lose the count
    if (cs_fall) begin
      lat_d = flg_s;
    end else if (cs_s) begin
      lat_d = lat_q;
    end else begin
      lat_d = lat_q | flg_s;
    end
    state_d = state_q;
    case (state_q)
      ST_NORMAL: begin
        if (cs_rise) state_d = mode_at_rise(state_q, lat_q[FI_GE2], lat_q[FI_GE10]);
      end
      ST_PDOWN: begin
        if (cs_fall) state_d = ST_WAKE;
      end
      ST_WAKE: begin
        if (cs_rise) state_d = mode_at_rise(state_q, lat_q[FI_GE2], lat_q[FI_GE10]);
      end
      default: state_d = ST_NORMAL;
    endcase
    // power-up timer
    // starts past zero so the sync lag of select counts toward the 1 us
    if (state_d == ST_PDOWN) begin
      pu_d = PU_SYNC;
    end else if (pu_q != PU_CYC) begin
      pu_d = pu_q + PU_W'(1);
    end else begin
      pu_d = pu_q;
    end
    // status outputs registered from next values, no decode at the pins
    rdy_d   = (pu_d == PU_CYC) && (state_d == ST_NORMAL);
    pdn_d   = (state_d == ST_PDOWN);
    // word only changes while no frame is running
    word_d  = (cs_s && an_q) ? {LEAD_ZEROS, CONV_DATA} : word_q;
    if (cs_fall) begin
      valid_d = (state_q == ST_NORMAL) && (pu_q == PU_CYC);
    end else begin
      valid_d = valid_q && (state_d == ST_NORMAL);
    end
    oe_d    = ~cs_s & ~flg_s[FI_DONE] & ~cs_rise;
    case (state_d)
      ST_PDOWN: track_d = 1'b0;
      ST_WAKE:  track_d = flg_s[FI_RISE];
      default:  track_d = cs_s | flg_s[FI_GE13];
    endcase
  end

  // ==========================================================
  // registers
  // ==========================================================
  // reset starts powered and tracking, as after supply ramp
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cs_prev_q <= 1'b1;
      lat_q     <= '0;
      state_q   <= ST_NORMAL;
      pu_q      <= PU_CYC;
      word_q    <= '0;
      valid_q   <= 1'b0;
      rdy_q     <= 1'b1;
      pdn_q     <= 1'b0;
      oe_q      <= 1'b0;
      an_q      <= 1'b1;
      track_q   <= 1'b1;
    end else begin
      cs_prev_q <= cs_s;
      lat_q     <= lat_d;
      state_q   <= state_d;
      pu_q      <= pu_d;
      word_q    <= word_d;
      valid_q   <= valid_d;
      rdy_q     <= rdy_d;
      pdn_q     <= pdn_d;
      oe_q      <= oe_d;
      an_q      <= (state_d != ST_PDOWN);
      track_q   <= track_d;
    end
  end

  assign link_bus.frame_word = word_q;
  assign CONV_RESULT_OUT_OE  = oe_q;
  assign ANALOG_ON           = an_q;
  assign TH_TRACK            = track_q;
  assign PWR_READY           = rdy_q;
  assign RESULT_VALID        = valid_q;
  assign MODE_PDOWN          = pdn_q;

  // ==========================================================
  // checks
  // ==========================================================
  localparam int PU_BOUND = PU_CYC_INT + 1;  // timer span plus registering cycle
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence s_rise_in_pd_window;
    (state_q == ST_NORMAL) && cs_rise && lat_q[FI_GE2] && !lat_q[FI_GE10];
  endsequence
  sequence s_wake_start;
    (state_q == ST_PDOWN) && cs_fall;
  endsequence

  chk_pd_entry: assert property (s_rise_in_pd_window |=> MODE_PDOWN && !ANALOG_ON)
    else $error("power-down window rise did not power down");
  chk_glitch_stay: assert property ((state_q == ST_NORMAL) && cs_rise && !lat_q[FI_GE2]
    |=> state_q == ST_NORMAL)
    else $error("early rise changed mode");
  chk_oe_release: assert property (cs_rise |=> !CONV_RESULT_OUT_OE [*2])
    else $error("output still driven after select rise");
  chk_pd_quiet: assert property (MODE_PDOWN |-> !ANALOG_ON && !TH_TRACK && !RESULT_VALID)
    else $error("analog active in power-down");
  chk_wake_start: assert property (s_wake_start |=> state_q == ST_WAKE ##0 ANALOG_ON)
    else $error("select fall did not start power-up");
  chk_wake_abort: assert property ((state_q == ST_WAKE) && cs_rise && !lat_q[FI_GE10]
    |=> MODE_PDOWN)
    else $error("short wake did not return to power-down");
  chk_ready_time: assert property (s_wake_start |-> ##[1:PU_BOUND]
    (pu_q == PU_CYC || MODE_PDOWN))
    else $error("not powered within one microsecond");
  chk_dummy_invalid: assert property ((state_q == ST_WAKE) |-> !RESULT_VALID)
    else $error("dummy conversion marked valid");
  chk_track_wake: assert property ((state_d == ST_WAKE) && flg_s[FI_RISE] |=> TH_TRACK)
    else $error("track/hold not tracking after first edge");
  chk_done_release: assert property (flg_s[FI_DONE] |=> !CONV_RESULT_OUT_OE)
    else $error("output driven after sixteenth fall");
endmodule // apms_top
`default_nettype wire

// ===== testbench/apms_host_model.sv
// host serial port model: frame select, serial clock and result capture
`timescale 1ns/1ps
`default_nettype none
module apms_host_model (
  // system clock that frame select is aligned to
  input  wire logic clk,
  // level seen on the serial result pin
  input  wire logic result_in,
  // frame select and serial clock toward the device
  output var  logic cs_n,
  output var  logic sclk
);
  import apms_pkg::*;
  // ==========================================================
  // idle levels
  // ==========================================================
  // select idles high, serial clock parked high outside frames; a short low
  // step at start gives the link a clean clearing edge whatever runs first
  initial begin
    cs_n = 1'b0;
    sclk = 1'b1;
    #1;
    cs_n = 1'b1;
  end
  // ==========================================================
  // frame tasks
  // ==========================================================
  // lower select, give n falling edges, return bits read msb first
  task automatic begin_frame(input int n, output logic [FRAME_LEN-1:0] word);
    word = 16'h0000;
    @(posedge clk);
    cs_n <= 1'b0;
    // odd offset keeps the link clock out of phase with clk
    #43;
    for (int i = 0; i < n; i++) begin
      // a bit is read just before the fall that replaces it
      word[FRAME_LEN-1-i] = result_in;
      sclk = 1'b0;
      #32;
      sclk = 1'b1;
      #32;
    end
  endtask
  // raise select, then keep it high long enough to be seen
  task automatic end_frame();
    @(posedge clk);
    cs_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
endmodule // apms_host_model
`default_nettype wire

// ===== testbench/apms_top_tb_top.sv
// self-checking bench of the adc power-mode sequencer
`timescale 1ns/1ps
`default_nettype none
module apms_top_tb_top;
  import apms_pkg::*;
  // ==========================================================
  // signals
  // ==========================================================
  logic             clk = 1'b0;       // system clock
  logic             rst_n = 1'b0;     // async reset
  logic             sclk;             // link clock from host
  logic             cs_n;             // frame select from host
  logic [RES_W-1:0] conv_data = 12'h000;  // converter result
  logic             conv_out;         // result bit
  logic             conv_oe;          // result pin enable
  logic             analog_on;        // analog powered
  logic             th_track;         // track when high
  logic             pwr_ready;        // fully powered
  logic             result_valid;     // frame carries valid data
  logic             mode_pdown;       // power-down state
  wire  logic       result_pin;       // resolved result pin
  int               fail_count = 0;   // mismatches
  int               n_checks = 0;     // comparisons made
  logic [FRAME_LEN-1:0] w;            // word read by host
  // undriven pin floats so a released output never reads as data
  assign result_pin = conv_oe ? conv_out : 1'bz;
  // clock of 8 ns period
  always #4 clk = ~clk;
  // ==========================================================
  // instances
  // ==========================================================
  apms_top i_apms_top (
    .CLK(clk), .RST_N(rst_n), .SCLK(sclk), .CS_N(cs_n), .CONV_DATA(conv_data),
    .CONV_RESULT_OUT(conv_out), .CONV_RESULT_OUT_OE(conv_oe), .ANALOG_ON(analog_on),
    .TH_TRACK(th_track), .PWR_READY(pwr_ready), .RESULT_VALID(result_valid),
    .MODE_PDOWN(mode_pdown)
  );
  apms_host_model i_apms_host_model (
    .clk(clk), .result_in(result_pin), .cs_n(cs_n), .sclk(sclk)
  );
  // ==========================================================
  // compare and closing tasks
  // ==========================================================
  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [FRAME_LEN-1:0] got, input logic [FRAME_LEN-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    if (fail_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // settle on a falling edge so registered outputs have landed
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask
  // ==========================================================
  // scenarios
  // ==========================================================
  // values straight after reset
  task automatic t_reset_vals();
    settle(1);
    chk_bit(th_track, 1'b1);
    chk_bit(analog_on, 1'b1);
    chk_bit(mode_pdown, 1'b0);
    chk_bit(pwr_ready, 1'b1);
    chk_bit(result_valid, 1'b0);
    chk_bit(conv_oe, 1'b0);
    chk_bit(conv_out, 1'b0);
  endtask
  // full 16-clock frame in normal mode
  task automatic t_full_frame(input logic [RES_W-1:0] d, input logic valid);
    @(posedge clk);
    conv_data <= d;
    repeat (3) @(posedge clk);
    i_apms_host_model.begin_frame(16, w);
    settle(5);
    chk_bit(conv_oe, 1'b0);
    chk_bit(th_track, 1'b1);
    chk_bit(result_valid, valid);
    i_apms_host_model.end_frame();
    chk_word(w, {LEAD_ZEROS, d});
    chk_bit(mode_pdown, 1'b0);
  endtask
  // select raised before the second fall
  task automatic t_glitch();
    for (int n = 0; n < 2; n++) begin
      i_apms_host_model.begin_frame(n, w);
      settle(1);
      chk_bit(conv_oe, 1'b1);
      i_apms_host_model.end_frame();
      chk_bit(mode_pdown, 1'b0);
      chk_bit(analog_on, 1'b1);
      chk_bit(conv_oe, 1'b0);
    end
  endtask
  // select raised inside the power-down window
  task automatic t_pdown(input int n);
    i_apms_host_model.begin_frame(n, w);
    i_apms_host_model.end_frame();
    chk_bit(mode_pdown, 1'b1);
    chk_bit(analog_on, 1'b0);
    chk_bit(th_track, 1'b0);
    chk_bit(conv_oe, 1'b0);
  endtask
  // burst of eight clocks must drop the device back to power-down
  task automatic t_abort_wake();
    i_apms_host_model.begin_frame(8, w);
    settle(1);
    chk_bit(analog_on, 1'b1);
    i_apms_host_model.end_frame();
    chk_bit(mode_pdown, 1'b1);
    chk_bit(analog_on, 1'b0);
  endtask
  // shortened dummy frame of ten clocks, then a valid frame
  task automatic t_wake(input logic [RES_W-1:0] d);
    i_apms_host_model.begin_frame(10, w);
    settle(1);
    chk_bit(th_track, 1'b1);
    chk_bit(analog_on, 1'b1);
    chk_bit(result_valid, 1'b0);
    i_apms_host_model.end_frame();
    chk_bit(mode_pdown, 1'b0);
    chk_bit(pwr_ready, 1'b0);
    // lands 996 ns after select fell: ready must already show
    settle(33);
    chk_bit(pwr_ready, 1'b1);
    t_full_frame(d, 1'b1);
  endtask
  // ==========================================================
  // main sequence and watchdog
  // ==========================================================
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset_vals();
    t_full_frame(12'hA5C, 1'b1);
    t_full_frame(12'hFFF, 1'b1);
    t_glitch();
    t_pdown(2);
    t_abort_wake();
    t_wake(12'h3C5);
    t_pdown(9);
    t_wake(12'h001);
    close_out();
  end
  // the whole run needs some 9 us; cut a hang short well after that
  initial begin
    #100000;
    fail_count++;
    close_out();
  end
endmodule // apms_top_tb_top
`default_nettype wire
